/* File: common/adcsq_pkg.sv */
package adcsq_pkg;
  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_DATA_PORT  = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_BOUNDS     = 8'h08;
  localparam logic [7:0] ADDR_CONTROL    = 8'h0C;
  localparam logic [7:0] ADDR_TEMP_CTRL  = 8'h10;
  localparam logic [7:0] ADDR_HOLD_CTRL  = 8'h14;
  localparam logic [7:0] ADDR_REF_AVG    = 8'h18;
  // ==========================================================================
  // sizes
  localparam int NUM_SLOTS   = 24;
  localparam int NUM_BUFS    = 25;
  localparam logic [4:0] LAST_SLOT   = 5'd23;
  localparam logic [4:0] LAST_BUF    = 5'd24;
  localparam logic [4:0] TEMP_BUF    = 5'd22;
  localparam logic [4:0] HOLD0_BUF   = 5'd23;
  localparam logic [4:0] HOLD1_BUF   = 5'd24;
  // ==========================================================================
  // status register fields
  localparam int ST_IDX_LSB   = 0;
  localparam int ST_CFG_BIT   = 8;
  localparam int ST_AVG_BIT   = 9;
  localparam int ST_AVAIL_BIT = 10;
  localparam int ST_TEMP_BIT  = 11;
  localparam int ST_HOLD0_BIT = 12;
  localparam int ST_HOLD1_BIT = 13;
  // bounds register fields
  localparam int BD_FIRST_LSB = 0;
  localparam int BD_LAST_LSB  = 8;
  // control register fields
  localparam int CN_DIV_LSB   = 0;
  localparam int CN_CONT_BIT  = 4;
  localparam int CN_GO_BIT    = 5;
  localparam int CN_LOC_BIT   = 6;
  // configuration slot fields
  localparam int CF_CHAN_LSB  = 0;
  localparam int CF_DIFF_BIT  = 5;
  localparam int CF_RANGE_LSB = 6;
  localparam int CF_ACQ_BIT   = 13;
  localparam int CF_LEFT_BIT  = 14;
  localparam int CF_ALT_LSB   = 8;
  localparam int REF_ON_BIT   = 0;
  // ==========================================================================
  // timing, in converter clocks and core clocks
  localparam int ACQ_CLKS     = 2;
  localparam int CONV_CLKS    = 13;
  localparam int READ_CLKS    = ACQ_CLKS + CONV_CLKS;
  localparam int READS_PER    = 2;
  localparam int PROC_CORE    = 4;
  localparam int POWERUP_CLKS = 20;
  localparam logic [31:0] RESP_OKAY   = 32'h0000_0000;
  localparam logic [1:0]  BRESP_OKAY  = 2'b00;
  localparam logic [1:0]  BRESP_SLVERR = 2'b10;
  // ==========================================================================
  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_POWERUP = 5'b00010,
    ST_SAMPLE  = 5'b00100,
    ST_PROCESS = 5'b01000,
    ST_STORE   = 5'b10000
  } adcsq_state_type;
  typedef enum logic [1:0] {
    SRC_VOLT  = 2'd0,
    SRC_HOLD0 = 2'd1,
    SRC_HOLD1 = 2'd2,
    SRC_TEMP  = 2'd3
  } adcsq_src_type;
endpackage : adcsq_pkg

/* File: tb/adcsq_asserts.sv */
`timescale 1ns/10ps
module adcsq_checker
  import adcsq_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [4:0] conv_channel,
  input wire logic       conv_sample
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // register bus
  sequence s_wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_wr_answer; !s_axi_awready ##1 s_axi_bvalid; endsequence
  property p_wr_walk; s_wr_taken |=> s_wr_answer; endproperty
  a_wr_walk: assert property (p_wr_walk) else $error("write answer late");
  property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_once: assert property (p_b_once) else $error("write answer repeated");
  property p_rd_walk; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd_walk: assert property (p_rd_walk) else $error("read answer late");
  property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_once: assert property (p_r_once) else $error("read answer repeated");
  // ==========================================================================
  // converter timing: one tick is at least 8 core clocks
  sequence s_acq; conv_sample [*8]; endsequence
  sequence s_conv; !conv_sample [*8]; endsequence
  property p_acq_len; $rose(conv_sample) |-> s_acq; endproperty
  a_acq_len: assert property (p_acq_len) else $error("acquisition too short");
  property p_conv_gap; $fell(conv_sample) |-> s_conv; endproperty
  a_conv_gap: assert property (p_conv_gap) else $error("conversion too short");
  property p_chan_steady; conv_sample && $past(conv_sample) |-> $stable(conv_channel); endproperty
  a_chan_steady: assert property (p_chan_steady) else $error("channel moved in acquisition");
  property p_chan_range; conv_sample |-> conv_channel <= LAST_BUF; endproperty
  a_chan_range: assert property (p_chan_range) else $error("channel out of range");
endmodule : adcsq_checker

bind adcsq_top adcsq_checker u_chk (.*);

/* File: tb/adcsq_conv_model.sv */
`timescale 1ns/10ps
module adcsq_conv_model
  import adcsq_pkg::*;
#(
  parameter int REF_WAIT = 250
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [4:0]  conv_channel,
  input  wire logic        conv_sample,
  input  wire logic        internal_ref_on,
  output logic      [12:0] conv_result
);
  int settle;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b || !internal_ref_on) settle <= 0;
    else if (settle < REF_WAIT) settle <= settle + 1;
  end
  // fixed code per channel; an unsettled reference reads as garbage
  always_comb begin
    if (settle < REF_WAIT) conv_result = ~{conv_channel, 8'h5A};
    else conv_result = {conv_channel, 8'h5A};
  end
endmodule : adcsq_conv_model

/* File: tb/tb_adc_sequence_controller.sv */
`timescale 1ns/10ps
module tb_adc_sequence_controller
  import adcsq_pkg::*;
;
  logic core_clk = 0, rst_b = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, hold0_ready = 0, hold1_ready = 0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_sample, internal_ref_on;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [4:0] conv_channel, seen[$];
  logic [12:0] conv_result;
  logic [4:0] fr[5] = '{5'd7, 5'd23, 5'd8, 5'd24, 5'd22};
  logic smp_q = 1'b0;
  int err_count = 0, n_compared = 0, n;
  typedef struct {logic [7:0] a; logic [31:0] d, m, e; logic [1:0] r;} adcsq_row_type;
  adcsq_row_type rows[5] = '{
    '{ADDR_BOUNDS, 32'h0000_0116, 32'h0000_1F1F, 32'h0000_0116, BRESP_OKAY},
    '{ADDR_REF_AVG, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001, BRESP_OKAY},
    '{ADDR_TEMP_CTRL, 32'h0000_0000, 32'h0000_0001, 32'h0000_0000, BRESP_OKAY},
    '{8'h1C, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000, BRESP_SLVERR},
    '{8'h02, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000, BRESP_SLVERR}};
  always #2 core_clk = ~core_clk;
  adcsq_top DUT (.*, .conv_diff(), .conv_range(), .conv_acq_ext());
  adcsq_conv_model u_conv (.*);
  // two readings per conversion, so each slot shows up twice
  always @(posedge core_clk) begin
    if (conv_sample && !smp_q) seen.push_back(conv_channel);
    smp_q <= conv_sample;
  end
  task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask : rd
  task automatic wait_idle();
    n = 0;
    do begin
      rd(ADDR_CONTROL);
      n++;
    end while (rdv[CN_GO_BIT] && n < 1000);
    chk("go cleared", rdv[CN_GO_BIT], 32'h0000_0000);
  endtask : wait_idle
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rd(ADDR_CONTROL);
    chk("control reset", rdv, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk("write resp", resp, rows[i].r);
      rd(rows[i].a);
      chk("read back", rdv & rows[i].m, rows[i].e);
    end
    repeat (300) @(posedge core_clk);
    // slots 22, 23, 0, 1 carry channels 5..8
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_STATUS, 32'h0000_0100 | 32'((22 + k) % 24));
      wr(ADDR_DATA_PORT, 32'h0000_0005 + 32'(k));
    end
    wr(ADDR_STATUS, 32'h0000_0000);
    seen.delete();
    wr(ADDR_CONTROL, 32'h0000_0020);
    @(posedge conv_sample);
    wr(ADDR_CONTROL, 32'h0000_0020);
    wait_idle();
    chk("conv count", seen.size(), 32'h0000_0008);
    foreach (seen[k]) chk("slot order", seen[k], 32'(5 + k / 2));
    rd(ADDR_STATUS);
    chk("avail set", rdv[ST_AVAIL_BIT], 32'h0000_0001);
    wr(ADDR_STATUS, 32'h0000_0005);
    rd(ADDR_STATUS);
    chk("avail clear", rdv[ST_AVAIL_BIT], 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      rd(ADDR_DATA_PORT);
      chk("result", rdv[12:0], {5'(5 + k), 8'h5A});
    end
    rd(ADDR_STATUS);
    chk("index step", rdv[4:0], 32'h0000_0009);
    wr(ADDR_STATUS, 32'h0000_0018);
    rd(ADDR_DATA_PORT);
    rd(ADDR_DATA_PORT);
    rd(ADDR_STATUS);
    chk("index wrap", rdv[4:0], 32'h0000_0001);
    seen.delete();
    wr(ADDR_CONTROL, 32'h0000_0030);
    @(posedge conv_sample);
    rd(ADDR_CONTROL);
    chk("go held", rdv[CN_GO_BIT], 32'h0000_0001);
    wr(ADDR_CONTROL, 32'h0000_0000);
    repeat (600) @(posedge core_clk);
    chk("stop count", seen.size(), 32'h0000_0002);
    // slots 0 and 1 with both holds ready and temperature on
    wr(ADDR_TEMP_CTRL, 32'h0000_0001);
    wr(ADDR_HOLD_CTRL, 32'h0000_0003);
    wr(ADDR_BOUNDS, 32'h0000_0100);
    hold0_ready <= 1'b1;
    hold1_ready <= 1'b1;
    seen.delete();
    wr(ADDR_CONTROL, 32'h0000_0020);
    wait_idle();
    chk("frame count", seen.size(), 32'h0000_000A);
    foreach (seen[k]) chk("frame order", seen[k], fr[k / 2]);
    rd(ADDR_STATUS);
    chk("frame flags", rdv[ST_HOLD1_BIT:ST_TEMP_BIT], 32'h0000_0007);
    wr(ADDR_STATUS, 32'h0000_0016);
    for (int k = 0; k < 3; k++) begin
      rd(ADDR_DATA_PORT);
      chk("fixed buffer", rdv[12:0], {5'(22 + k), 8'h5A});
    end
    wr(ADDR_TEMP_CTRL, 32'h0000_0000);
    wr(ADDR_CONTROL, 32'h0000_0020);
    wait_idle();
    rd(ADDR_STATUS);
    chk("temp off", rdv[ST_TEMP_BIT], 32'h0000_0000);
    wrap_up();
  end
endmodule : tb_adc_sequence_controller

/* File: verilog/adcsq_top.sv */
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int DATA_W = 13
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        hold0_ready,
  input  wire logic        hold1_ready,
  input  wire logic [DATA_W-1:0] conv_result,
  output logic [4:0]       conv_channel,
  output logic             conv_diff,
  output logic [1:0]       conv_range,
  output logic             conv_acq_ext,
  output logic             conv_sample,
  output logic             internal_ref_on
);

  // ==========================================================================
  // register storage
  logic [15:0] cfg_slot [NUM_SLOTS];
  logic [1:0]  avg_slot [NUM_SLOTS];
  logic [15:0] result_buf [NUM_BUFS];
  logic [4:0]  slot_index;
  logic        config_select_flag;
  logic        avg_select_flag;
  logic        data_avail_flag;
  logic        temp_done_flag;
  logic        hold0_done_flag;
  logic        hold1_done_flag;
  logic [4:0]  seq_first_slot;
  logic [4:0]  seq_last_slot;
  logic [2:0]  conv_clock_divider;
  logic        continuous_select;
  logic        convert_go;
  logic        loc_override;
  logic        temp_enable;
  logic [1:0]  hold_enable;
  logic        stop_req;

  adcsq_state_type state;
  adcsq_src_type   src;
  logic [4:0]  cur_slot;
  logic        hold_turn_one;
  logic        powered;
  logic        seq_done;
  logic [7:0]  div_cnt;
  logic        conv_tick;
  logic [5:0]  clk_cnt;
  logic [3:0]  proc_cnt;
  logic [DATA_W:0] acc;

  function automatic logic [4:0] adcsq_next_slot(input logic [4:0] s);
    adcsq_next_slot = (s == LAST_SLOT) ? 5'd0 : s + 5'd1;
  endfunction : adcsq_next_slot

  function automatic logic [4:0] adcsq_next_buf(input logic [4:0] b);
    adcsq_next_buf = (b == LAST_BUF) ? 5'd0 : b + 5'd1;
  endfunction : adcsq_next_buf

  // ==========================================================================
  // axi-lite handshake: one write, one read at a time
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        rd_fire;
  logic        wr_map;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_map  = (aw_addr <= ADDR_REF_AVG) && (aw_addr[1:0] == 2'b00);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= BRESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? BRESP_OKAY : BRESP_SLVERR;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // read path; reads of the data port in result mode move the index
  logic [31:0] rd_word;
  logic        rd_map;

  always_comb begin
    rd_word = RESP_OKAY;
    rd_map  = 1'b1;
    unique case (s_axi_araddr)
      ADDR_DATA_PORT: begin
        if (config_select_flag && !avg_select_flag) begin
          rd_word[15:0] = cfg_slot[slot_index];
        end else if (avg_select_flag && !config_select_flag) begin
          rd_word[1:0] = avg_slot[slot_index];
        end else begin
          rd_word[15:0] = result_buf[slot_index];
        end
      end
      ADDR_STATUS: begin
        rd_word[ST_IDX_LSB +: 5] = slot_index;
        rd_word[ST_CFG_BIT]      = config_select_flag;
        rd_word[ST_AVG_BIT]      = avg_select_flag;
        rd_word[ST_AVAIL_BIT]    = data_avail_flag;
        rd_word[ST_TEMP_BIT]     = temp_done_flag;
        rd_word[ST_HOLD0_BIT]    = hold0_done_flag;
        rd_word[ST_HOLD1_BIT]    = hold1_done_flag;
      end
      ADDR_BOUNDS: begin
        rd_word[BD_FIRST_LSB +: 5] = seq_first_slot;
        rd_word[BD_LAST_LSB +: 5]  = seq_last_slot;
      end
      ADDR_CONTROL: begin
        rd_word[CN_DIV_LSB +: 3] = conv_clock_divider;
        rd_word[CN_CONT_BIT]     = continuous_select;
        rd_word[CN_GO_BIT]       = convert_go;
        rd_word[CN_LOC_BIT]      = loc_override;
      end
      ADDR_TEMP_CTRL: rd_word[0]      = temp_enable;
      ADDR_HOLD_CTRL: rd_word[1:0]    = hold_enable;
      ADDR_REF_AVG:   rd_word[REF_ON_BIT] = internal_ref_on;
      default:        rd_map = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= BRESP_OKAY;
    end else begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_map ? BRESP_OKAY : BRESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // software registers
  logic wr_data_port;
  logic wr_status;
  logic wr_control;
  logic go_write_one;
  logic go_start;
  logic rd_result;

  assign wr_data_port = wr_fire && aw_addr == ADDR_DATA_PORT && w_strb[0];
  assign wr_status    = wr_fire && aw_addr == ADDR_STATUS && w_strb[1];
  assign wr_control   = wr_fire && aw_addr == ADDR_CONTROL && w_strb[0];
  assign go_write_one = wr_control && w_data[CN_GO_BIT];
  assign go_start     = go_write_one && !convert_go;
  assign rd_result    = rd_fire && s_axi_araddr == ADDR_DATA_PORT
                        && !config_select_flag && !avg_select_flag;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        cfg_slot[i] <= 16'h0000;
        avg_slot[i] <= 2'b00;
      end
    end else if (wr_data_port && w_strb[1] && slot_index <= LAST_SLOT) begin
      if (config_select_flag && !avg_select_flag) begin
        cfg_slot[slot_index] <= w_data[15:0];
      end else if (avg_select_flag && !config_select_flag) begin
        avg_slot[slot_index] <= w_data[1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      slot_index         <= 5'd0;
      config_select_flag <= 1'b0;
      avg_select_flag    <= 1'b0;
    end else if (wr_fire && aw_addr == ADDR_STATUS && w_strb[0]) begin
      slot_index <= w_data[ST_IDX_LSB +: 5] > LAST_BUF ? 5'd0 : w_data[ST_IDX_LSB +: 5];
      if (w_strb[1]) begin
        config_select_flag <= w_data[ST_CFG_BIT];
        avg_select_flag    <= w_data[ST_AVG_BIT];
      end
    end else if (rd_result) begin
      slot_index <= adcsq_next_buf(slot_index);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_first_slot     <= 5'd0;
      seq_last_slot      <= 5'd0;
      conv_clock_divider <= 3'd0;
      continuous_select  <= 1'b0;
      loc_override       <= 1'b0;
      temp_enable        <= 1'b0;
      hold_enable        <= 2'b00;
      internal_ref_on    <= 1'b0;
    end else if (wr_fire) begin
      if (aw_addr == ADDR_BOUNDS && w_strb[0] && w_data[4:0] <= LAST_SLOT) begin
        seq_first_slot <= w_data[BD_FIRST_LSB +: 5];
      end
      if (aw_addr == ADDR_BOUNDS && w_strb[1] && w_data[12:8] <= LAST_SLOT) begin
        seq_last_slot <= w_data[BD_LAST_LSB +: 5];
      end
      if (wr_control) begin
        conv_clock_divider <= w_data[CN_DIV_LSB +: 3];
        continuous_select  <= w_data[CN_CONT_BIT];
        loc_override       <= w_data[CN_LOC_BIT];
      end
      if (aw_addr == ADDR_TEMP_CTRL && w_strb[0]) begin
        temp_enable <= w_data[0];
      end
      if (aw_addr == ADDR_HOLD_CTRL && w_strb[0]) begin
        hold_enable <= w_data[1:0];
      end
      if (aw_addr == ADDR_REF_AVG && w_strb[0]) begin
        internal_ref_on <= w_data[REF_ON_BIT];
      end
    end
  end

  // ==========================================================================
  // converter clock: one tick per 2*(divider+1)*4 core clocks
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt   <= 8'd0;
      conv_tick <= 1'b0;
    end else if (div_cnt == {conv_clock_divider, 3'b111}) begin
      div_cnt   <= 8'd0;
      conv_tick <= 1'b1;
    end else begin
      div_cnt   <= div_cnt + 8'd1;
      conv_tick <= 1'b0;
    end
  end

  // ==========================================================================
  // sequencer
  logic [15:0] cur_cfg;
  logic [4:0]  store_loc;
  logic        hold_pick;

  assign cur_cfg   = cfg_slot[cur_slot];
  assign hold_pick = (hold_enable[0] && hold0_ready) || (hold_enable[1] && hold1_ready);
  assign store_loc = src == SRC_TEMP  ? TEMP_BUF :
                     src == SRC_HOLD0 ? HOLD0_BUF :
                     src == SRC_HOLD1 ? HOLD1_BUF :
                     loc_override ? cur_cfg[CF_ALT_LSB +: 5] : cur_cfg[CF_CHAN_LSB +: 5];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state         <= ST_IDLE;
      src           <= SRC_VOLT;
      cur_slot      <= 5'd0;
      hold_turn_one <= 1'b0;
      powered       <= 1'b0;
      seq_done      <= 1'b0;
      clk_cnt       <= 6'd0;
      proc_cnt      <= 4'd0;
      acc           <= '0;
      stop_req      <= 1'b0;
      convert_go    <= 1'b0;
      conv_sample   <= 1'b0;
      for (int i = 0; i < NUM_BUFS; i++) begin
        result_buf[i] <= 16'h0000;
      end
    end else begin
      if (wr_control && !w_data[CN_GO_BIT] && convert_go) begin
        stop_req <= 1'b1;
      end
      unique case (state)
        ST_IDLE: begin
          powered <= 1'b0;
          if (go_start) begin
            convert_go <= 1'b1;
            stop_req   <= 1'b0;
            cur_slot   <= seq_first_slot;
            src        <= SRC_VOLT;
            seq_done   <= 1'b0;
            clk_cnt    <= 6'd0;
            state      <= ST_POWERUP;
          end
        end
        ST_POWERUP: begin
          if (conv_tick) begin
            clk_cnt <= clk_cnt + 6'd1;
          end
          if (powered || (conv_tick && clk_cnt == 6'(POWERUP_CLKS - 1))) begin
            powered     <= 1'b1;
            clk_cnt     <= 6'd0;
            acc         <= '0;
            conv_sample <= 1'b1;
            state       <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (conv_tick) begin
            clk_cnt <= clk_cnt + 6'd1;
            if (clk_cnt == 6'(ACQ_CLKS - 1)) begin
              conv_sample <= 1'b0;
            end
            if (clk_cnt == 6'(READ_CLKS * READS_PER - 1)) begin
              proc_cnt <= 4'd0;
              state    <= ST_PROCESS;
            end
            if (clk_cnt == 6'(READ_CLKS - 1)) begin
              acc <= {1'b0, conv_result};
            end
            if (clk_cnt == 6'(READ_CLKS)) begin
              conv_sample <= 1'b1;
            end
            if (clk_cnt == 6'(READ_CLKS + ACQ_CLKS - 1)) begin
              conv_sample <= 1'b0;
            end
          end
        end
        ST_PROCESS: begin
          proc_cnt <= proc_cnt + 4'd1;
          if (proc_cnt == 4'd0) begin
            acc <= acc + {1'b0, conv_result};
          end
          if (proc_cnt == 4'(PROC_CORE * READS_PER - 1)) begin
            state <= ST_STORE;
          end
        end
        ST_STORE: begin
          result_buf[store_loc] <= cur_cfg[CF_LEFT_BIT] && src == SRC_VOLT
                                   ? 16'({acc[DATA_W:1], 3'b000}) : 16'(acc[DATA_W:1]);
          clk_cnt <= 6'd0;
          acc     <= '0;
          if (src == SRC_VOLT) begin
            seq_done <= cur_slot == seq_last_slot;
            cur_slot <= cur_slot == seq_last_slot ? seq_first_slot : adcsq_next_slot(cur_slot);
          end
          if (src == SRC_HOLD0 || src == SRC_HOLD1) begin
            hold_turn_one <= src == SRC_HOLD0;
          end
          // pick the next source: hold between voltages, temperature at sequence end
          // the next conversion reopens through power-up (no wait once powered), so the mux outputs
          // are already settled when acquisition starts
          if (stop_req) begin
            convert_go <= 1'b0;
            state      <= ST_IDLE;
          end else if (src == SRC_VOLT && hold_pick) begin
            src <= (hold_enable[1] && hold1_ready && (hold_turn_one || !(hold_enable[0] && hold0_ready)))
                   ? SRC_HOLD1 : SRC_HOLD0;
            state <= ST_POWERUP;
          end else if ((src == SRC_VOLT ? cur_slot == seq_last_slot : seq_done) && temp_enable
                       && src != SRC_TEMP) begin
            src         <= SRC_TEMP;
            state       <= ST_POWERUP;
          end else if ((src == SRC_VOLT ? cur_slot == seq_last_slot : seq_done) && !continuous_select) begin
            convert_go <= 1'b0;
            state      <= ST_IDLE;
          end else begin
            src         <= SRC_VOLT;
            seq_done    <= 1'b0;
            state       <= ST_POWERUP;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // completion flags; a hardware set beats a software clear
  logic stored;
  assign stored = state == ST_STORE && !stop_req;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_avail_flag <= 1'b0;
      temp_done_flag  <= 1'b0;
      hold0_done_flag <= 1'b0;
      hold1_done_flag <= 1'b0;
    end else begin
      if (stored && src == SRC_VOLT && cur_slot == seq_last_slot) begin
        data_avail_flag <= 1'b1;
      end else if (go_start || (wr_status && !w_data[ST_AVAIL_BIT])) begin
        data_avail_flag <= 1'b0;
      end
      if (state == ST_STORE && src == SRC_TEMP) begin
        temp_done_flag <= 1'b1;
      end else if (wr_status && !w_data[ST_TEMP_BIT]) begin
        temp_done_flag <= 1'b0;
      end
      if (state == ST_STORE && src == SRC_HOLD0) begin
        hold0_done_flag <= 1'b1;
      end else if (wr_status && !w_data[ST_HOLD0_BIT]) begin
        hold0_done_flag <= 1'b0;
      end
      if (state == ST_STORE && src == SRC_HOLD1) begin
        hold1_done_flag <= 1'b1;
      end else if (wr_status && !w_data[ST_HOLD1_BIT]) begin
        hold1_done_flag <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // converter mux outputs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_channel <= 5'd0;
      conv_diff    <= 1'b0;
      conv_range   <= 2'b00;
      conv_acq_ext <= 1'b0;
    end else begin
      conv_channel <= store_loc;
      conv_diff    <= src == SRC_VOLT && cur_cfg[CF_DIFF_BIT];
      conv_range   <= src == SRC_VOLT ? cur_cfg[CF_RANGE_LSB +: 2] : 2'b00;
      conv_acq_ext <= src == SRC_VOLT && cur_cfg[CF_ACQ_BIT];
    end
  end

endmodule : adcsq_top
